/* verilog/uart_fmt_pkg.sv */
package uart_fmt_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_SOURCE    = 8'h00;
  localparam logic [7:0] OFS_FORMAT    = 8'h04;
  localparam logic [7:0] OFS_CONTROL   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  // ==========================================================================
  // Line format field positions
  localparam int FMT_DIV_ACCESS = 7;
  localparam int FMT_BREAK      = 6;
  localparam int FMT_PAR_STICK  = 5;
  localparam int FMT_PAR_EVEN   = 4;
  localparam int FMT_PAR_EN     = 3;
  localparam int FMT_STOP       = 2;
  localparam int FMT_LEN_HI     = 1;
  localparam int FMT_LEN_LO     = 0;

  // Control register field positions
  localparam int CTL_FIFO_EN    = 0;
  localparam int CTL_ENHANCED   = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] FORMAT_RESET  = 8'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [7:0] IRQ_RESET     = 8'h00;

  // ==========================================================================
  // Interrupt source codes, bits 5:0
  localparam logic [5:0] CODE_NONE     = 6'h01;
  localparam logic [5:0] CODE_LINE     = 6'h06;
  localparam logic [5:0] CODE_RXDATA   = 6'h04;
  localparam logic [5:0] CODE_RXTIMEO  = 6'h0C;
  localparam logic [5:0] CODE_THR      = 6'h02;
  localparam logic [5:0] CODE_MODEM    = 6'h00;
  localparam logic [5:0] CODE_XOFF     = 6'h10;
  localparam logic [5:0] CODE_FLOW     = 6'h20;
  localparam logic [1:0] FIFO_MARK     = 2'h3;

  // Stop length in half bit times
  localparam logic [2:0] STOP_ONE      = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO      = 3'h4;

  // Data bits for word length code 00
  localparam logic [3:0] WORD_BASE     = 4'h5;

  // ==========================================================================
  // Source order doubles as priority order: lower value wins
  typedef enum logic [2:0] {
    SRC_NONE, SRC_LINE, SRC_RXDATA, SRC_RXTIMEO, SRC_THR, SRC_MODEM, SRC_XOFF, SRC_FLOW
  } src_t;

  typedef enum logic [1:0] {PAR_ODD, PAR_EVEN, PAR_ONE, PAR_ZERO} par_t;

endpackage

/* verilog/uart_irq_status_line_format.sv */
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Register map
// 0x00 source status, read only
//   Bits 7:6 both high while the FIFO enable control bit is set
//   Bits 5:0 carry the code of the one source being reported
//   Code 01 means nothing pending, so bit 0 low flags a live source
//   Writes here are dropped without any response other than OKAY
// 0x04 line format, read and write, clears to zero
//   Bit 7 routes accesses to the divisor and enhanced registers
//   Bit 6 forces the serial line low for a break
//   Bits 5:3 pick parity, bit 2 the stop length, bits 1:0 the word
// 0x08 control, read and write
//   Bit 0 FIFO enable, only reflected in the source status mark
//   Bit 1 enhanced enable, gates the Xoff and flow sources
// 0x0C interrupt status, write one to clear
//   Bits 7:1 follow the sources in priority order, bit 0 unused
// 0x10 interrupt mask, same layout as the status, bit 0 reads 0
// Any other address reads zero and ignores writes

// ==========================================================================
// Bus timing
// The slave never inserts wait states: hreadyout is high from the
// first edge after reset release. An address phase is captured at the
// edge where hready, hsel and htrans bit 1 are seen together. For a
// write, the data phase value is committed at the following edge. For
// a read, the read word is built from next state at the address edge,
// so a read straight after a write already sees the new value.
// Limitation: while clk_en is low the bus is still answered as ready,
// but nothing is captured, so a master must not talk to us then.

// ==========================================================================
// Source reporting
// One source is reported at a time. It is latched once chosen and it
// stays latched while its input stays high, even if a higher source
// turns up meanwhile. Only when it drops does the scan pick again, and
// then the highest pending source wins. Servicing a source means its
// input going low; reads never service anything.
// Trade-off: latching costs one registered field but gives software a
// stable answer across several reads of the same interrupt.
// Source status and interrupt status reads already show the inputs of
// the address edge, because the read word is built from next state;
// only an Xoff or Xon pulse shows one edge later, via the Xoff flag.

// ==========================================================================
// Flow control sources
// The Xoff flag is sticky: a match pulse sets it and only a matching
// Xon pulse drops it. When both pulses meet in one cycle the set wins,
// which keeps the far side paused rather than risking an overrun.
// Both the Xoff and the flow source count only with enhanced enable;
// the flag itself still tracks pulses while the gate is closed.

// ==========================================================================
// Line format outputs
// Word length, stop length and parity are decoded here and registered,
// so the transmitter and receiver see settled values one edge after a
// write data phase. Stop length is given in half bit times so the one
// and a half case needs no fraction downstream.
// Parity code 101 gives a bit forced to one; 001 gives odd parity.
// The break forcing acts on the registered line copy, so the serial
// output lags the transmitter's bit by one clock in normal running.

// ==========================================================================
// Interrupt output
// Status bits are sticky and set while their source is high. A clear
// write and a new event in the same cycle leave the bit set, so no
// event is lost between a read and its clear. The level output is high
// while any set status bit is also unmasked.

module uart_irq_status_line_format (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        line_error,
  input  wire logic        receive_data_available,
  input  wire logic        receive_timeout,
  input  wire logic        transmit_holding_empty,
  input  wire logic        modem_change,
  input  wire logic        xoff_match,
  input  wire logic        xon_match,
  input  wire logic        flow_change,
  input  wire logic        tx_serial,
  output logic             tx_line,
  output logic             divisor_access,
  output logic [3:0]       word_bits,
  output logic [2:0]       stop_halves,
  output logic             parity_enable,
  output logic [1:0]       parity_mode,
  output logic             irq
);

  // ==========================================================================
  // State record
  typedef struct packed {
    logic                 wr_pend;
    logic [4:0]           wr_sel;
    logic [7:0]           format;
    logic [1:0]           control;
    logic [7:0]           irq_stat;
    logic [7:0]           irq_mask;
    logic                 xoff_held;
    uart_fmt_pkg::src_t   held;
    logic [31:0]          rdata;
    logic                 irq;
    logic                 tx_line;
    logic [3:0]           word_bits;
    logic [2:0]           stop_halves;
    logic                 parity_en;
    uart_fmt_pkg::par_t   parity_mode;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // ==========================================================================
  // Helpers
  // Address decode, used by both the read and the write path
  function automatic logic [4:0] reg_hit(input logic [31:0] addr);
    logic [4:0] hit;
    hit = 5'h00;
    if (addr[31:8] == 24'h00_0000)
    begin
      hit[0] = (addr[7:0] == uart_fmt_pkg::OFS_SOURCE);
      hit[1] = (addr[7:0] == uart_fmt_pkg::OFS_FORMAT);
      hit[2] = (addr[7:0] == uart_fmt_pkg::OFS_CONTROL);
      hit[3] = (addr[7:0] == uart_fmt_pkg::OFS_IRQ_STAT);
      hit[4] = (addr[7:0] == uart_fmt_pkg::OFS_IRQ_MASK);
    end
    return hit;
  endfunction

  // Source to its printed code
  function automatic logic [5:0] src_code(input uart_fmt_pkg::src_t src);
    logic [5:0] code;
    code = uart_fmt_pkg::CODE_NONE;
    case (src)
      uart_fmt_pkg::SRC_LINE:    code = uart_fmt_pkg::CODE_LINE;
      uart_fmt_pkg::SRC_RXDATA:  code = uart_fmt_pkg::CODE_RXDATA;
      uart_fmt_pkg::SRC_RXTIMEO: code = uart_fmt_pkg::CODE_RXTIMEO;
      uart_fmt_pkg::SRC_THR:     code = uart_fmt_pkg::CODE_THR;
      uart_fmt_pkg::SRC_MODEM:   code = uart_fmt_pkg::CODE_MODEM;
      uart_fmt_pkg::SRC_XOFF:    code = uart_fmt_pkg::CODE_XOFF;
      uart_fmt_pkg::SRC_FLOW:    code = uart_fmt_pkg::CODE_FLOW;
      default:                   code = uart_fmt_pkg::CODE_NONE;
    endcase
    return code;
  endfunction

  // ==========================================================================
  // Next-state logic
  logic [7:0]         pend;
  logic [4:0]         a_hit;
  logic               a_take;
  logic [7:0]         clr;
  uart_fmt_pkg::src_t best;
  logic [7:0]         src_rd;
  logic [7:0]         fmt;

  always_comb
  begin
    nxt_s = s_ff;
    clr   = 8'h00;
    best  = uart_fmt_pkg::SRC_NONE;

    // Write data phase commits the address captured one cycle earlier
    if (s_ff.wr_pend)
    begin
      if (s_ff.wr_sel[1])
        nxt_s.format = hwdata[7:0];
      if (s_ff.wr_sel[2])
        nxt_s.control = hwdata[1:0];
      if (s_ff.wr_sel[3])
        clr = hwdata[7:0];
      if (s_ff.wr_sel[4])
        nxt_s.irq_mask = {1'b0, hwdata[7:1]} << 1;
    end

    // Xoff flag: sticky, only a matching Xon drops it; a new match wins
    if (xoff_match)
      nxt_s.xoff_held = 1'b1;
    else if (xon_match)
      nxt_s.xoff_held = 1'b0;

    // Pending vector indexed by source; bit 0 never used
    pend    = 8'h00;
    pend[1] = line_error;
    pend[2] = receive_data_available;
    pend[3] = receive_timeout;
    pend[4] = transmit_holding_empty;
    pend[5] = modem_change;
    pend[6] = s_ff.xoff_held & s_ff.control[uart_fmt_pkg::CTL_ENHANCED];
    pend[7] = flow_change & s_ff.control[uart_fmt_pkg::CTL_ENHANCED];

    // Lowest source value wins, so scan from the top down and let the last hit stand
    for (int i = 7; i >= 1; i--)
    begin
      if (pend[i])
        best = uart_fmt_pkg::src_t'(3'(i));
    end

    // Keep the reported source while it is still unserviced
    if (s_ff.held != uart_fmt_pkg::SRC_NONE && pend[s_ff.held])
      nxt_s.held = s_ff.held;
    else
      nxt_s.held = best;

    // Sticky event bits; a new event beats a clear in the same cycle
    nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | pend;
    nxt_s.irq      = |(nxt_s.irq_stat & nxt_s.irq_mask);

    // Read value is built from next state so a write just before is seen
    src_rd = {(nxt_s.control[uart_fmt_pkg::CTL_FIFO_EN] ?
               uart_fmt_pkg::FIFO_MARK : 2'h0),
              src_code(nxt_s.held)};
    a_take = hready & hsel & htrans[1];
    a_hit  = reg_hit(haddr);
    nxt_s.wr_pend = a_take & hwrite;
    nxt_s.wr_sel  = a_hit;
    if (a_take & ~hwrite)
    begin
      nxt_s.rdata = 32'h0000_0000;
      case (1'b1)
        a_hit[0]: nxt_s.rdata = {24'h00_0000, src_rd};
        a_hit[1]: nxt_s.rdata = {24'h00_0000, nxt_s.format};
        a_hit[2]: nxt_s.rdata = {30'h0000_0000, nxt_s.control};
        a_hit[3]: nxt_s.rdata = {24'h00_0000, nxt_s.irq_stat};
        a_hit[4]: nxt_s.rdata = {24'h00_0000, nxt_s.irq_mask};
        default:  nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // Line format decode, registered so the outputs come from flops
    fmt = nxt_s.format;
    nxt_s.tx_line   = fmt[uart_fmt_pkg::FMT_BREAK] ? 1'b0 : tx_serial;
    nxt_s.word_bits = uart_fmt_pkg::WORD_BASE +
                      {2'h0, fmt[uart_fmt_pkg::FMT_LEN_HI:uart_fmt_pkg::FMT_LEN_LO]};
    if (!fmt[uart_fmt_pkg::FMT_STOP])
      nxt_s.stop_halves = uart_fmt_pkg::STOP_ONE;
    else if (fmt[uart_fmt_pkg::FMT_LEN_HI:uart_fmt_pkg::FMT_LEN_LO] == 2'h0)
      nxt_s.stop_halves = uart_fmt_pkg::STOP_ONE_HALF;
    else
      nxt_s.stop_halves = uart_fmt_pkg::STOP_TWO;
    nxt_s.parity_en = fmt[uart_fmt_pkg::FMT_PAR_EN];
    case ({fmt[uart_fmt_pkg::FMT_PAR_STICK], fmt[uart_fmt_pkg::FMT_PAR_EVEN]})
      2'h1:    nxt_s.parity_mode = uart_fmt_pkg::PAR_EVEN;
      2'h2:    nxt_s.parity_mode = uart_fmt_pkg::PAR_ONE;
      2'h3:    nxt_s.parity_mode = uart_fmt_pkg::PAR_ZERO;
      default: nxt_s.parity_mode = uart_fmt_pkg::PAR_ODD;
    endcase
  end

  // ==========================================================================
  // State register; clock enable low freezes everything
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_ff.wr_pend     <= 1'b0;
      s_ff.wr_sel      <= 5'h00;
      s_ff.format      <= uart_fmt_pkg::FORMAT_RESET;
      s_ff.control     <= uart_fmt_pkg::CONTROL_RESET;
      s_ff.irq_stat    <= uart_fmt_pkg::IRQ_RESET;
      s_ff.irq_mask    <= uart_fmt_pkg::IRQ_RESET;
      s_ff.xoff_held   <= 1'b0;
      s_ff.held        <= uart_fmt_pkg::SRC_NONE;
      s_ff.rdata       <= 32'h0000_0000;
      s_ff.irq         <= 1'b0;
      s_ff.tx_line     <= 1'b1;
      s_ff.word_bits   <= uart_fmt_pkg::WORD_BASE;
      s_ff.stop_halves <= uart_fmt_pkg::STOP_ONE;
      s_ff.parity_en   <= 1'b0;
      s_ff.parity_mode <= uart_fmt_pkg::PAR_ODD;
    end
    else if (clk_en)
    begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register; hreadyout has its own flop, hresp is tied low
  logic hready_ff;

  // Zero wait states: the slave never stalls the bus
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hready_ff <= 1'b0;
    else
      hready_ff <= 1'b1;
  end

  assign hrdata         = s_ff.rdata;
  assign hreadyout      = hready_ff;
  assign hresp          = 1'b0;
  assign tx_line        = s_ff.tx_line;
  assign divisor_access = s_ff.format[uart_fmt_pkg::FMT_DIV_ACCESS];
  assign word_bits      = s_ff.word_bits;
  assign stop_halves    = s_ff.stop_halves;
  assign parity_enable  = s_ff.parity_en;
  assign parity_mode    = s_ff.parity_mode;
  assign irq            = s_ff.irq;

endmodule

`default_nettype wire

/* testbench/event_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Far-side event levels and serial bit source
module event_source_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] want,
  output logic      [7:0] level,
  output logic            xoff_pulse,
  output logic            xon_pulse,
  output logic            tx_bit
);
  // Registered so levels behave like same-clock logic; xoff and xon are pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      level      <= 8'h00;
      xoff_pulse <= 1'b0;
      xon_pulse  <= 1'b0;
      tx_bit     <= 1'b1;
    end
    else
    begin
      level      <= want;
      xoff_pulse <= want[6] & ~level[6];
      xon_pulse  <= ~want[6] & level[6];
      tx_bit     <= ~tx_bit; // Toggles so a stale copy shows
    end
  end
endmodule
`default_nettype wire

/* testbench/uart_fmt_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port-level checks
module uart_fmt_checker (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       clk_en,
  input wire logic       tx_serial,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       tx_line,
  input wire logic [3:0] word_bits,
  input wire logic [2:0] stop_halves
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("slave stalled");
  a_word_range: assert property (word_bits inside {[4'h5:4'h8]})
    else $error("word length out of range");
  a_stop_half: assert property (stop_halves == 3'h3 |-> word_bits == 4'h5)
    else $error("half stop with long word");
  a_stop_two: assert property (stop_halves == 3'h4 |-> word_bits != 4'h5)
    else $error("two stops with short word");
  a_stop_set: assert property (stop_halves inside {3'h2, 3'h3, 3'h4})
    else $error("bad stop length");
  // High line means no break, so it must copy the serial bit
  a_tx_follow: assert property ($past(hresetn) && $past(clk_en) && tx_line |-> $past(tx_serial))
    else $error("line high without serial one");
  a_fmt_freeze: assert property ($past(hresetn) && !$past(clk_en) |-> $stable(word_bits))
    else $error("format moved while frozen");
endmodule
bind uart_irq_status_line_format uart_fmt_checker i_uart_fmt_checker (.hclk(hclk),
  .hresetn(hresetn), .clk_en(clk_en), .tx_serial(tx_serial), .hreadyout(hreadyout),
  .hresp(hresp), .tx_line(tx_line), .word_bits(word_bits), .stop_halves(stop_halves));
`default_nettype wire

/* testbench/uart_irq_status_line_format_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench
module uart_irq_status_line_format_tb;
  logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, irq, xoff_p, xon_p;
  logic        tx_serial, tx_line, divisor_access, parity_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  want, level;
  logic [3:0]  word_bits;
  logic [2:0]  stop_halves;
  logic [1:0]  htrans, parity_mode;
  int          fails = 0, total_checks = 0, cyc = 0;
  uart_irq_status_line_format i_uart_irq_status_line_format (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_error(level[1]), .receive_data_available(level[2]),
    .receive_timeout(level[3]), .transmit_holding_empty(level[4]), .modem_change(level[5]),
    .xoff_match(xoff_p), .xon_match(xon_p), .flow_change(level[7]), .tx_serial(tx_serial),
    .tx_line(tx_line), .divisor_access(divisor_access), .word_bits(word_bits),
    .stop_halves(stop_halves), .parity_enable(parity_enable), .parity_mode(parity_mode),
    .irq(irq));
  event_source_model i_event_source_model (.hclk(hclk), .hresetn(hresetn), .want(want),
    .level(level), .xoff_pulse(xoff_p), .xon_pulse(xon_p), .tx_bit(tx_serial));
  // Clock and hang guard
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  // One single AHB transfer; waits on hready, no fixed latency assumed
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e, m);
  endtask
  task settle;
    repeat (4) @(posedge hclk);
  endtask
  // Reset values, refused accesses
  task reset_vals;
    bus(1'b1, 8'h00, 32'h0000_00FF);
    rd_chk(8'h00, 32'h0000_0001, "source idle");
    rd_chk(8'h04, 32'h0000_0000, "format reset");
    rd_chk(8'h20, 32'h0000_0000, "unmapped read");
    chk(divisor_access, 1'b0, "divisor reset");
  endtask
  // Every word, stop and parity setting
  task format_scan;
    for (int i = 0; i < 64; i++)
    begin
      bus(1'b1, 8'h04, 32'(i));
      settle;
      rd_chk(8'h04, 32'(i), "format readback");
      chk(word_bits, 32'(i % 4 + 5), "word length");
      chk(stop_halves, !i[2] ? 32'h2 : (i % 4 == 0 ? 32'h3 : 32'h4), "stop length");
      chk(parity_enable, i[3], "parity enable");
      if (i[3])
        chk(parity_mode, 32'(i / 16), "parity mode");
    end
  endtask
  // Break holds line low; frozen clock enable keeps format
  task break_div;
    bus(1'b1, 8'h04, 32'h0000_00C0);
    settle;
    repeat (3)
    begin
      @(negedge hclk);
      chk(tx_line, 1'b0, "break low");
    end
    chk(divisor_access, 1'b1, "divisor access");
    @(posedge hclk);
    clk_en <= 1'b0;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    bus(1'b1, 8'h04, 32'h0000_0000);
    settle;
    @(negedge hclk);
    chk(tx_line, !tx_serial, "line follows");
  endtask
  // Reported source stays until serviced, FIFO mark off
  task priority_hold;
    want <= 8'h10;
    settle;
    rd_chk(8'h00, 32'h0000_0002, "holding empty");
    want <= 8'h12;
    settle;
    rd_chk(8'h00, 32'h0000_0002, "not preempted");
    want <= 8'h02;
    settle;
    rd_chk(8'h00, 32'h0000_0006, "next after service");
    want <= 8'h00;
    settle;
  endtask
  task enhanced_off;
    bus(1'b1, 8'h08, 32'h0000_0001);
    want <= 8'hC0;
    settle;
    rd_chk(8'h00, 32'h0000_00C1, "upper sources gated");
    want <= 8'h00;
    settle;
  endtask
  // All sources, serviced highest first, then interrupt mask and clear
  task order_scan;
    logic [5:0] code [8] = '{6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
    bus(1'b1, 8'h08, 32'h0000_0003);
    want <= 8'hFE;
    settle;
    for (int i = 0; i < 8; i++)
    begin
      rd_chk(8'h00, {24'h00_0000, 2'h3, code[i]}, "priority order");
      if (i < 7)
        want[i + 1] <= 1'b0;
      settle;
    end
    rd_chk(8'h0C, 32'h0000_00FE, "sticky status");
    chk(irq, 1'b0, "masked irq");
    bus(1'b1, 8'h10, 32'h0000_0002);
    settle;
    chk(irq, 1'b1, "unmasked irq");
    bus(1'b1, 8'h0C, 32'h0000_00FE);
    settle;
    rd_chk(8'h0C, 32'h0000_0000, "status cleared");
    chk(irq, 1'b0, "irq cleared");
  endtask
  initial
  begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    want = 8'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_vals;
    format_scan;
    break_div;
    priority_hold;
    enhanced_off;
    order_scan;
    test_done;
  end
endmodule
`default_nettype wire
